// file: inc/csb_pkg.sv
// package: register map, field positions, reset values and timing for the controller status bits block
package csb_pkg;
	// register byte offsets
	localparam logic [7:0] CSB_OFF_CTRL = 8'h00;
	localparam logic [7:0] CSB_OFF_FAULT = 8'h04;
	localparam logic [7:0] CSB_OFF_FLAGS = 8'h08;
	localparam logic [7:0] CSB_OFF_IRQ_STATUS = 8'h0c;
	localparam logic [7:0] CSB_OFF_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] CSB_OFF_IRQ_CLEAR = 8'h14;
	localparam logic [7:0] CSB_OFF_PAIR_FAULT = 8'h18;
	// ctrl register fields
	localparam int CSB_CTRL_RUN = 0;
	localparam int CSB_CTRL_FORCE = 1;
	localparam int CSB_CTRL_VERIFIED = 2;
	localparam int CSB_CTRL_LATE_REV = 3;
	localparam int CSB_CTRL_CYCLE = 4;
	// fault register fields, each bit high while that fault is present
	localparam int CSB_F_OUT_TEST = 0;
	localparam int CSB_F_OUT_PLAUS = 1;
	localparam int CSB_F_OUT_INT = 2;
	localparam int CSB_F_IN_TEST = 3;
	localparam int CSB_F_IN_INT = 4;
	localparam int CSB_F_SUPPLY_ONE = 5;
	localparam int CSB_F_SUPPLY_TWO = 6;
	localparam int CSB_F_OVERCURRENT = 7;
	// flags register fields
	localparam int CSB_S_OUTPUT_OK = 0;
	localparam int CSB_S_INPUT_OK = 1;
	localparam int CSB_S_FIRST_CYCLE = 2;
	localparam int CSB_S_EXTERNAL_OK = 3;
	localparam int CSB_S_FORCE = 4;
	localparam int CSB_S_LOGIC_ZERO = 5;
	localparam int CSB_S_LOGIC_ONE = 6;
	localparam int CSB_S_VERIFIED = 7;
	localparam int CSB_S_INTERNAL = 8;
	localparam int CSB_NFLAGS = 9;
	// interrupt event positions
	localparam int CSB_IRQ_OUT_FAULT = 0;
	localparam int CSB_IRQ_IN_FAULT = 1;
	localparam int CSB_IRQ_EXT_FAULT = 2;
	localparam int CSB_IRQ_START = 3;
	localparam int CSB_NIRQ = 4;
	// reset values
	localparam logic [31:0] CSB_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CSB_FAULT_RESET = 32'h0000_0000;
	// indicator blink timing
	localparam int CSB_CLK_HZ = 25_000_000;
	localparam int CSB_BLINK_HZ = 1;
	localparam int CSB_BLINK_HALF_CYCLES = CSB_CLK_HZ / (2 * CSB_BLINK_HZ);
	// logic cycle period in clock cycles
	localparam int CSB_LOGIC_CYCLE_DEFAULT = 250;
	// axi responses
	localparam logic [1:0] CSB_RESP_OKAY = 2'h0;
	localparam logic [1:0] CSB_RESP_SLVERR = 2'h2;
endpackage : csb_pkg

// file: rtl/csb_pair_eval.sv
`timescale 1ns/1ps
// two-channel input pair: latched timeout and sequence faults
module csb_pair_eval #(
	parameter int SYNC_W = 16 // width of the synchronous time counter
) (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic tick, // one logic cycle strobe
	input wire logic chan_a, // channel a, already synchronised
	input wire logic chan_b, // channel b, already synchronised
	input wire logic discrepant_mode, // 1 selects discrepant evaluation
	input wire logic [SYNC_W-1:0] sync_limit, // synchronous time in logic cycles, 0 disables
	output logic fault // latched timeout or sequence fault
);
	import csb_pkg::*;

	typedef struct packed {
		logic [SYNC_W-1:0] timer;
		logic timeout;
		logic seq_err;
		logic was_active;
		logic seen_inactive;
	} csb_pair_t;

	csb_pair_t pair_q, pair_d;
	logic inactive, active;

	initial begin
		if (SYNC_W < 1) $error("csb_pair_eval: SYNC_W must be at least 1");
	end

	// pair states for both evaluation types
	assign inactive = discrepant_mode ? (!chan_a && chan_b) : (!chan_a && !chan_b);
	assign active = discrepant_mode ? (chan_a && !chan_b) : (chan_a && chan_b);
	assign fault = pair_q.timeout | pair_q.seq_err;

	// faults clear only when the pair is back at inactive
	always_comb begin
		pair_d = pair_q;
		if (tick) begin
			if (inactive) begin
				pair_d.timer = '0;
				pair_d.timeout = 1'b0;
				pair_d.seq_err = 1'b0;
				pair_d.seen_inactive = 1'b1;
				pair_d.was_active = 1'b0;
			end else if (active) begin
				pair_d.timer = '0;
				// active again without passing inactive is a sequence fault
				if (!pair_q.seen_inactive) pair_d.seq_err = 1'b1;
				pair_d.seen_inactive = 1'b0;
				pair_d.was_active = 1'b1;
			end else if (sync_limit != '0) begin
				if (pair_q.timer >= sync_limit) pair_d.timeout = 1'b1;
				else pair_d.timer = pair_q.timer + 1'b1;
			end
		end
	end

	// register the pair state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pair_q <= '0;
		end else begin
			pair_q <= pair_d;
		end
	end
endmodule : csb_pair_eval

// file: rtl/csb_blinker.sv
`timescale 1ns/1ps
// verification indicator driver: steady when verified, else blinking
module csb_blinker #(
	parameter int HALF_CYCLES = 12_500_000 // clock cycles per half blink period
) (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic verified, // configuration verified
	output logic indicator // indicator drive, high lit
);
	import csb_pkg::*;

	localparam int CW = $clog2(HALF_CYCLES + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic phase;
		logic ind;
	} csb_blink_t;

	csb_blink_t blk_q, blk_d;

	initial begin
		if (HALF_CYCLES < 1) $error("csb_blinker: HALF_CYCLES must be at least 1");
	end

	assign indicator = blk_q.ind;

	// half-period counter toggles the phase
	always_comb begin
		blk_d = blk_q;
		if (blk_q.cnt == CW'(HALF_CYCLES - 1)) begin
			blk_d.cnt = '0;
			blk_d.phase = ~blk_q.phase;
		end else begin
			blk_d.cnt = blk_q.cnt + 1'b1;
		end
		blk_d.ind = verified ? 1'b1 : blk_d.phase;
	end

	// register the blink state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// start one count in so the first dark half after reset is no longer than the rest
			blk_q <= '0;
			blk_q.cnt <= CW'(HALF_CYCLES > 1 ? 1 : 0);
		end else begin
			blk_q <= blk_d;
		end
	end
endmodule : csb_blinker

// file: rtl/csb_status_bits.sv
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
// controller status bits: internal status inputs for the user logic program, axi4-lite slave
// Function
// - Output summary is high with no output test pulse, plausibility or internal output fault, else low.
// - Input summary is low while any input has a sequence, sync timeout, test pulse or internal fault.
// - Start pulse is high for only the first logic cycle after stop-to-run, low otherwise.
// - External summary is low while either output supply or output overcurrent is faulty.
// - On later hardware revisions the external summary also goes low on output or input faults.
// - Override mode flag is high while forcing is active, low otherwise.
// - Two constant sources are provided, one always low and one high from the first logic cycle after reset.
// - Verified flag high lights the indicator steadily; otherwise flag low and indicator blinks at 1 Hz.
// - A latched pair timeout or sequence fault clears only when the pair returns to inactive.
module csb_status_bits #(
	parameter int NPAIRS = 4, // number of two-channel input pairs
	parameter int SYNC_W = 16, // synchronous time counter width
	parameter int CYCLE_W = 16, // logic cycle length counter width
	parameter int BLINK_HALF = csb_pkg::CSB_BLINK_HALF_CYCLES // half blink period in clock cycles
) (
	input wire logic aclk, // 25 mhz clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [7:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [7:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic [NPAIRS-1:0] pair_a_pin, // channel a pins of the input pairs
	input wire logic [NPAIRS-1:0] pair_b_pin, // channel b pins of the input pairs
	output logic [csb_pkg::CSB_NFLAGS-1:0] status_flags, // flag vector seen by the logic program
	output logic verification_indicator, // indicator drive, high lit
	output logic irq // level interrupt
);
	import csb_pkg::*;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] fault;
		logic [NPAIRS-1:0] pair_mode;
		logic [SYNC_W-1:0] sync_limit;
		logic [CYCLE_W-1:0] cyc_cnt;
		logic run_seen;
		logic [CSB_NFLAGS-1:0] flags;
		logic [CSB_NIRQ-1:0] irq_st;
		logic [CSB_NIRQ-1:0] irq_en;
		logic irq;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [NPAIRS-1:0] sa1, sa2, sa3, sb1, sb2, sb3, fa, fb;
	} csb_state_t;

	csb_state_t st_q, st_d;
	logic [NPAIRS-1:0] pair_fault;
	logic tick;
	logic ind;

	initial begin
		if (NPAIRS < 1 || NPAIRS > 16) $error("csb_status_bits: NPAIRS must be 1..16");
		if (SYNC_W < 1 || SYNC_W > 16) $error("csb_status_bits: SYNC_W must be 1..16");
		if (CYCLE_W < 2 || CYCLE_W > 16) $error("csb_status_bits: CYCLE_W must be 2..16");
	end

	// merge byte lanes of a write into an old word
	function automatic logic [31:0] csb_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction : csb_merge

	// logic cycle strobe from the programmable cycle length
	assign tick = (st_q.cyc_cnt == '0);

	// one evaluator per input pair
	for (genvar g = 0; g < NPAIRS; g++) begin : g_pair
		csb_pair_eval #(
			.SYNC_W(SYNC_W)
		) u_pair (
			.aclk(aclk),
			.aresetn(aresetn),
			.tick(tick),
			.chan_a(st_q.fa[g]),
			.chan_b(st_q.fb[g]),
			.discrepant_mode(st_q.pair_mode[g]),
			.sync_limit(st_q.sync_limit),
			.fault(pair_fault[g])
		);
	end

	csb_blinker #(
		.HALF_CYCLES(BLINK_HALF)
	) u_blink (
		.aclk(aclk),
		.aresetn(aresetn),
		.verified(st_q.ctrl[CSB_CTRL_VERIFIED]),
		.indicator(ind)
	);

	assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
	assign s_axi_wready = !st_q.w_got && !st_q.bvalid;
	assign s_axi_arready = !st_q.rvalid;
	assign s_axi_bvalid = st_q.bvalid;
	assign s_axi_bresp = st_q.bresp;
	assign s_axi_rvalid = st_q.rvalid;
	assign s_axi_rdata = st_q.rdata;
	assign s_axi_rresp = st_q.rresp;
	assign status_flags = st_q.flags;
	assign irq = st_q.irq;

	// indicator leaves through one more flop; the verified flag's next value lights it in the same edge as the flag
	logic ind_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) ind_q <= 1'b0;
		else ind_q <= st_d.flags[CSB_S_VERIFIED] | ind;
	end
	assign verification_indicator = ind_q;

	// next-state logic: pins, cycle, flags, interrupts, bus
	always_comb begin
		logic out_ok, in_ok, ext_ok, start;
		logic [CSB_NIRQ-1:0] ev, clr;
		logic [7:0] wa;
		logic [31:0] wd;
		out_ok = 1'b0;
		in_ok = 1'b0;
		ext_ok = 1'b0;
		start = 1'b0;
		ev = '0;
		clr = '0;
		wa = '0;
		wd = '0;
		st_d = st_q;
		// three-stage synchronisers; a change counts when stages two and three agree
		st_d.sa1 = pair_a_pin;
		st_d.sa2 = st_q.sa1;
		st_d.sa3 = st_q.sa2;
		st_d.sb1 = pair_b_pin;
		st_d.sb2 = st_q.sb1;
		st_d.sb3 = st_q.sb2;
		for (int i = 0; i < NPAIRS; i++) begin
			if (st_q.sa2[i] == st_q.sa3[i]) st_d.fa[i] = st_q.sa3[i];
			if (st_q.sb2[i] == st_q.sb3[i]) st_d.fb[i] = st_q.sb3[i];
		end
		// logic cycle counter; a zero length would stall, so it floors at one
		if (tick) st_d.cyc_cnt = (st_q.ctrl[CSB_CTRL_CYCLE +: CYCLE_W] == '0) ? '0 :
			st_q.ctrl[CSB_CTRL_CYCLE +: CYCLE_W] - 1'b1;
		else st_d.cyc_cnt = st_q.cyc_cnt - 1'b1;
		// summaries
		out_ok = !(st_q.fault[CSB_F_OUT_TEST] | st_q.fault[CSB_F_OUT_PLAUS] | st_q.fault[CSB_F_OUT_INT]);
		in_ok = !(st_q.fault[CSB_F_IN_TEST] | st_q.fault[CSB_F_IN_INT] | (|pair_fault));
		ext_ok = !(st_q.fault[CSB_F_SUPPLY_ONE] | st_q.fault[CSB_F_SUPPLY_TWO]
			| st_q.fault[CSB_F_OVERCURRENT]);
		if (st_q.ctrl[CSB_CTRL_LATE_REV]) ext_ok = ext_ok & out_ok & in_ok;
		start = st_q.ctrl[CSB_CTRL_RUN] && !st_q.run_seen;
		// flags sampled together once per logic cycle
		if (tick) begin
			st_d.run_seen = st_q.ctrl[CSB_CTRL_RUN];
			st_d.flags[CSB_S_OUTPUT_OK] = out_ok;
			st_d.flags[CSB_S_INPUT_OK] = in_ok;
			st_d.flags[CSB_S_FIRST_CYCLE] = start;
			st_d.flags[CSB_S_EXTERNAL_OK] = ext_ok;
			st_d.flags[CSB_S_FORCE] = st_q.ctrl[CSB_CTRL_FORCE];
			st_d.flags[CSB_S_LOGIC_ZERO] = 1'b0;
			st_d.flags[CSB_S_LOGIC_ONE] = 1'b1;
			st_d.flags[CSB_S_VERIFIED] = st_q.ctrl[CSB_CTRL_VERIFIED];
			st_d.flags[CSB_S_INTERNAL] = 1'b1;
			// events on falling summaries and the start pulse
			ev[CSB_IRQ_OUT_FAULT] = st_q.flags[CSB_S_OUTPUT_OK] & !out_ok;
			ev[CSB_IRQ_IN_FAULT] = st_q.flags[CSB_S_INPUT_OK] & !in_ok;
			ev[CSB_IRQ_EXT_FAULT] = st_q.flags[CSB_S_EXTERNAL_OK] & !ext_ok;
			ev[CSB_IRQ_START] = start;
		end
		// write channel: address and data taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			st_d.aw_got = 1'b1;
			st_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_d.w_got = 1'b1;
			st_d.w_data = s_axi_wdata;
			st_d.w_strb = s_axi_wstrb;
		end
		if (st_q.aw_got && st_q.w_got) begin
			st_d.aw_got = 1'b0;
			st_d.w_got = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = CSB_RESP_OKAY;
			wa = {st_q.aw_addr[7:2], 2'b00};
			case (wa)
				CSB_OFF_CTRL: st_d.ctrl = csb_merge(st_q.ctrl, st_q.w_data, st_q.w_strb);
				CSB_OFF_FAULT: st_d.fault = csb_merge(st_q.fault, st_q.w_data, st_q.w_strb);
				CSB_OFF_FLAGS: st_d.bresp = CSB_RESP_OKAY;
				CSB_OFF_IRQ_STATUS: st_d.bresp = CSB_RESP_OKAY;
				CSB_OFF_IRQ_ENABLE: begin
					wd = csb_merge({28'h0, st_q.irq_en}, st_q.w_data, st_q.w_strb);
					st_d.irq_en = wd[CSB_NIRQ-1:0];
				end
				CSB_OFF_IRQ_CLEAR: begin
					wd = csb_merge(32'h0, st_q.w_data, st_q.w_strb);
					clr = wd[CSB_NIRQ-1:0];
				end
				CSB_OFF_PAIR_FAULT: begin
					wd = csb_merge(32'({st_q.sync_limit, 16'(st_q.pair_mode)}), st_q.w_data, st_q.w_strb);
					st_d.pair_mode = wd[NPAIRS-1:0];
					st_d.sync_limit = wd[16 +: SYNC_W];
				end
				default: st_d.bresp = CSB_RESP_SLVERR;
			endcase
		end
		if (st_q.bvalid && s_axi_bready) st_d.bvalid = 1'b0;
		// sticky status: a new event wins over a clear in the same cycle
		st_d.irq_st = (st_q.irq_st & ~clr) | ev;
		st_d.irq = |(st_d.irq_st & st_d.irq_en);
		// read channel
		if (s_axi_arvalid && s_axi_arready) begin
			st_d.rvalid = 1'b1;
			st_d.rresp = CSB_RESP_OKAY;
			case ({s_axi_araddr[7:2], 2'b00})
				CSB_OFF_CTRL: st_d.rdata = st_q.ctrl;
				CSB_OFF_FAULT: st_d.rdata = st_q.fault;
				CSB_OFF_FLAGS: st_d.rdata = {{(32-CSB_NFLAGS){1'b0}}, st_q.flags};
				CSB_OFF_IRQ_STATUS: st_d.rdata = {28'h0, st_q.irq_st};
				CSB_OFF_IRQ_ENABLE: st_d.rdata = {28'h0, st_q.irq_en};
				CSB_OFF_IRQ_CLEAR: st_d.rdata = 32'h0;
				CSB_OFF_PAIR_FAULT: st_d.rdata = 32'({st_q.sync_limit, 16'(pair_fault)});
				default: begin
					st_d.rdata = 32'h0;
					st_d.rresp = CSB_RESP_SLVERR;
				end
			endcase
		end else if (st_q.rvalid && s_axi_rready) begin
			st_d.rvalid = 1'b0;
		end
	end

	// register all state; flags reset to all zero, including the summaries and constants
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= '0;
			st_q.ctrl <= CSB_CTRL_RESET;
			st_q.fault <= CSB_FAULT_RESET;
			st_q.ctrl[CSB_CTRL_CYCLE +: CYCLE_W] <= CYCLE_W'(CSB_LOGIC_CYCLE_DEFAULT);
		end else begin
			st_q <= st_d;
		end
	end
endmodule : csb_status_bits

// file: verification/csb_status_bits_checker.sv
// checker: concurrent assertions on the status bits block ports
`timescale 1ns/1ps
module csb_status_bits_checker #(
	parameter int BLINK_HALF = 4 // half blink period in clocks
) (
	input wire logic aclk, // clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [csb_pkg::CSB_NFLAGS-1:0] status_flags, // flag vector
	input wire logic verification_indicator, // indicator drive
	input wire logic irq // level interrupt
);
	logic [1:0] up_q;
	int dark_q;
	// flags are only meaningful once the first tick after reset has loaded them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			up_q <= 2'h0;
		end else begin
			up_q <= {up_q[0], 1'h1};
		end
	end
	// dark phase length; a lost toggle shows as an overlong dark phase
	always_ff @(posedge aclk) begin
		if (!aresetn || verification_indicator) begin
			dark_q <= 0;
		end else begin
			dark_q <= dark_q + 1;
		end
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// the step check assumes the bench keeps a four-clock logic cycle
	const_zero_a: assert property (&up_q |-> !status_flags[5]) else $error("logic zero flag high");
	const_one_a: assert property (&up_q |-> status_flags[6]) else $error("logic one flag low");
	internal_one_a: assert property (&up_q |-> status_flags[8]) else $error("internal flag low");
	flags_step_a: assert property ($changed(status_flags) |=> $stable(status_flags) [*3])
		else $error("flags changed inside a logic cycle");
	start_pulse_a: assert property ($rose(status_flags[2]) |=> status_flags[2] [*3] ##1 !status_flags[2])
		else $error("start pulse not one logic cycle");
	steady_lit_a: assert property (status_flags[7] |-> verification_indicator)
		else $error("indicator dark while verified");
	blink_dark_a: assert property (dark_q <= BLINK_HALF) else $error("indicator dark too long");
	reset_clear_a: assert property (disable iff (1'b0) !aresetn |=> status_flags == '0 && !irq && !verification_indicator)
		else $error("outputs not cleared by reset");
	start_c: cover property ($rose(status_flags[2]));
	blink_c: cover property ($fell(verification_indicator));
	irq_c: cover property ($rose(irq));
endmodule : csb_status_bits_checker

// file: verification/csb_status_bits_test.sv
// testbench: axi4-lite stimulus and flag checks for the status bits block
`timescale 1ns/1ps
module csb_status_bits_test;
	import csb_pkg::*;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [7:0] awaddr = 8'h0;
	logic [7:0] araddr = 8'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awvalid = 1'h0;
	logic wvalid = 1'h0;
	logic bready = 1'h0;
	logic arvalid = 1'h0;
	logic rready = 1'h0;
	logic [3:0] pa = 4'h0;
	logic [3:0] pb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid, ind, irq, hs_a, hs_w, hs_r;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [CSB_NFLAGS-1:0] flags;
	logic [33:0] exp_q[$];
	int fails = 0;
	int checked = 0;
	csb_status_bits #(.NPAIRS(4), .BLINK_HALF(4)) DUT (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pair_a_pin(pa), .pair_b_pin(pb), .status_flags(flags),
		.verification_indicator(ind), .irq(irq));
	initial begin
		forever #20 aclk = ~aclk;
	end
	task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic stop_test;
		$display("checked=%0d fails=%0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test
	// handshakes are judged on the falling edge, where nothing is still moving
	always @(negedge aclk) begin
		if (rvalid && rready) cmp({rresp, rdata}, exp_q.pop_front());
		if (bvalid && bready) cmp({bresp, 32'h0}, exp_q.pop_front());
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = CSB_RESP_OKAY);
		exp_q.push_back({r, 32'h0});
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(negedge aclk);
			hs_a = awvalid && awready;
			hs_w = wvalid && wready;
			hs_r = bvalid;
			@(posedge aclk);
			if (hs_a) awvalid <= 1'h0;
			if (hs_w) wvalid <= 1'h0;
		end while (!hs_r);
		bready <= 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = CSB_RESP_OKAY);
		exp_q.push_back({r, d});
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(negedge aclk);
			hs_a = arvalid && arready;
			hs_r = rvalid;
			@(posedge aclk);
			if (hs_a) arvalid <= 1'h0;
		end while (!hs_r);
		rready <= 1'h0;
	endtask : rd
	// expected flag word from fault bits and control settings
	function automatic logic [31:0] flg(input logic [7:0] f, input logic frc, late, ver, pair);
		logic o, i, e;
		o = !(f[0] | f[1] | f[2]);
		i = !(f[3] | f[4] | pair);
		e = !(f[5] | f[6] | f[7]) && !(late && !(o && i));
		return {23'h0, 1'h1, ver, 1'h1, 1'h0, frc, e, 1'h0, i, o};
	endfunction : flg
	initial begin
		logic [7:0] f;
		int k;
		void'($urandom(41865));
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		rd(CSB_OFF_CTRL, 32'h0000_0fa0);
		rd(CSB_OFF_FAULT, 32'h0);
		rd(CSB_OFF_IRQ_CLEAR, 32'h0);
		rd(8'h1c, 32'h0, CSB_RESP_SLVERR);
		wr(8'h1c, 32'hffff_ffff, CSB_RESP_SLVERR);
		wr(CSB_OFF_FLAGS, 32'h0);
		wr(CSB_OFF_CTRL, 32'h0000_0040);
		$display("register test done");
		// stop to run: start flag lasts one four-clock logic cycle
		wr(CSB_OFF_CTRL, 32'h0000_0041);
		k = 0;
		@(negedge aclk);
		// the old 250-clock logic cycle may still be running down before the short one takes over
		while (flags[CSB_S_FIRST_CYCLE] !== 1'h1 && k < 300) begin
			@(negedge aclk);
			k++;
		end
		k = 0;
		while (flags[CSB_S_FIRST_CYCLE] === 1'h1 && k < 20) begin
			@(negedge aclk);
			k++;
		end
		cmp(34'(k), 34'h4);
		$display("start test done");
		// random faults under every force and revision setting
		for (int j = 0; j < 8; j++) begin
			f = 8'($urandom());
			wr(CSB_OFF_CTRL, {28'h0000004, j[0], 1'h0, j[1], 1'h1});
			wr(CSB_OFF_FAULT, {24'h0, f});
			repeat (10) @(posedge aclk);
			rd(CSB_OFF_FLAGS, flg(f, j[1], j[0], 1'h0, 1'h0));
		end
		$display("flags test done");
		// event while masked, then enabled, then cleared
		wr(CSB_OFF_CTRL, 32'h0000_0041);
		wr(CSB_OFF_FAULT, 32'h0);
		repeat (10) @(posedge aclk);
		wr(CSB_OFF_IRQ_CLEAR, 32'hf);
		wr(CSB_OFF_IRQ_ENABLE, 32'h0);
		rd(CSB_OFF_IRQ_STATUS, 32'h0);
		wr(CSB_OFF_FAULT, 32'h1);
		repeat (10) @(posedge aclk);
		rd(CSB_OFF_IRQ_STATUS, 32'h1);
		cmp({33'h0, irq}, 34'h0);
		wr(CSB_OFF_IRQ_ENABLE, 32'h1);
		rd(CSB_OFF_IRQ_ENABLE, 32'h1);
		cmp({33'h0, irq}, 34'h1);
		wr(CSB_OFF_IRQ_CLEAR, 32'h1);
		rd(CSB_OFF_IRQ_STATUS, 32'h0);
		cmp({33'h0, irq}, 34'h0);
		$display("interrupt test done");
		// pair 0 times out, goes active with the fault held, then inactive clears it
		wr(CSB_OFF_FAULT, 32'h0);
		wr(CSB_OFF_PAIR_FAULT, 32'h0002_0000);
		pa <= 4'h1;
		repeat (40) @(posedge aclk);
		rd(CSB_OFF_PAIR_FAULT, 32'h0002_0001);
		rd(CSB_OFF_FLAGS, flg(8'h0, 1'h0, 1'h0, 1'h0, 1'h1));
		pb <= 4'h1;
		repeat (20) @(posedge aclk);
		rd(CSB_OFF_PAIR_FAULT, 32'h0002_0001);
		pa <= 4'h0;
		pb <= 4'h0;
		repeat (20) @(posedge aclk);
		rd(CSB_OFF_PAIR_FAULT, 32'h0002_0000);
		rd(CSB_OFF_FLAGS, flg(8'h0, 1'h0, 1'h0, 1'h0, 1'h0));
		$display("pair test done");
		// unverified: a toggle every four clocks; verified: steadily lit
		k = 0;
		@(negedge aclk);
		for (int j = 0; j < 32; j++) begin
			f[0] = ind;
			@(negedge aclk);
			if (ind !== f[0]) k++;
		end
		cmp(34'(k), 34'h8);
		wr(CSB_OFF_CTRL, 32'h0000_0045);
		repeat (10) @(posedge aclk);
		rd(CSB_OFF_FLAGS, flg(8'h0, 1'h0, 1'h0, 1'h1, 1'h0));
		k = 0;
		repeat (16) begin
			@(negedge aclk);
			if (ind !== 1'h1) k++;
		end
		cmp(34'(k), 34'h0);
		$display("indicator test done");
		stop_test;
	end
	// the whole sequence needs well under a thousand clocks
	initial begin
		repeat (20000) @(posedge aclk);
		fails++;
		stop_test;
	end
endmodule : csb_status_bits_test
bind csb_status_bits csb_status_bits_checker #(.BLINK_HALF(BLINK_HALF)) chk (.aclk(aclk), .aresetn(aresetn),
	.status_flags(status_flags), .verification_indicator(verification_indicator), .irq(irq));
